/* verilog/prc_pkg.sv */
// Purpose: shared types and constants of the pump remote i/o controller
// Assumes: 10 MHz core clock
// Notes: timing figures are kept in their own unit, cycle counts derive from them
package prc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // timing figures as printed, and derived cycle counts
  localparam longint unsigned PULSE_MS = 200;
  localparam longint unsigned WARMUP_S = 10;
  localparam longint unsigned FLOW_HOLD_MIN = 15;
  localparam longint unsigned DEBOUNCE_MS = 10;
  localparam longint unsigned PULSE_CYC = (PULSE_MS * CLK_HZ) / 1000;
  localparam longint unsigned WARMUP_CYC = WARMUP_S * CLK_HZ;
  localparam longint unsigned FLOW_HOLD_CYC = FLOW_HOLD_MIN * 60 * CLK_HZ;
  localparam longint unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ) / 1000;
  // counter widths
  localparam int unsigned DEB_W = 17;
  localparam int unsigned PW_W = 21;
  localparam int unsigned WU_W = 27;
  localparam int unsigned FH_W = 34;
  // contact input indices
  localparam int unsigned NIN = 9;
  localparam int unsigned IN_MP_START = 0;
  localparam int unsigned IN_BP_START = 1;
  localparam int unsigned IN_RESET = 2;
  localparam int unsigned IN_MP_STOP = 3;
  localparam int unsigned IN_BP_STOP = 4;
  localparam int unsigned IN_LOC_START = 5;
  localparam int unsigned IN_LOC_STOP = 6;
  localparam int unsigned IN_LOC_RESET = 7;
  localparam int unsigned IN_REMOTE = 8;
  // alarm bit positions
  localparam int unsigned AL_WATER = 0;
  localparam int unsigned AL_SEAL = 1;
  localparam int unsigned AL_DIL = 2;
  // configuration switches, captured once after power-up
  typedef struct packed {
    logic data_8bit;      // on: 8-bit serial characters
    logic sup_op_only;    // on: flow supervision only while running
    logic auto_stop_rem;  // on: stop pumps on change to remote
    logic pulse_mode;     // on: momentary start/stop inputs
    logic zero_dil;       // on: zero-dilution mode
    logic bp_by_signal;   // on: booster follows remote signals
  } prc_cfg_t;
  localparam prc_cfg_t CFG_RESET = '{data_8bit: 1'b1, sup_op_only: 1'b0, auto_stop_rem: 1'b0,
                                     pulse_mode: 1'b0, zero_dil: 1'b0, bp_by_signal: 1'b0};
  // raw alarm and trip causes from the sensing logic
  typedef struct packed {
    logic [7:0] alarm;    // 0 water,1 seal,2 dil flow low,3 casing,4 mp cur,5 bp cur,6 oil,7 bearing
    logic [7:0] trip;     // casing,mp motor,bp motor,mp ovl,bp ovl,phase,leak,exhaust
    logic dil_valve_open; // dilution selector valve open
    logic inlet_vac_ok;   // inlet vacuum allows booster
    logic estop_closed;   // emergency stop switch closed
  } prc_sense_t;
  // status outputs toward the equipment
  typedef struct packed {
    logic main_pump_run;
    logic booster_pump_run;
    logic estop_ok;       // high while emergency stop is cleared
    logic remote;
    logic alarm_any;
    logic trip_any;
    logic [7:0] alarm;
    logic [7:0] trip;
    logic buzzer;
    logic start_fail;
    logic ready;          // warm-up finished
    logic data_8bit;
  } prc_stat_t;
endpackage : prc_pkg

/* verilog/prc_remote_io.sv */
// Purpose: remote control and status logic of a vacuum pump controller
// Assumes: contact inputs active high, synchronous reset at power-up
// Notes: all state sits in one struct registered by one process
`timescale 1ns/1ps
`default_nettype none
module prc_remote_io #(
  parameter logic [prc_pkg::PW_W-1:0] PULSE_CYC = prc_pkg::PW_W'(prc_pkg::PULSE_CYC),
  parameter logic [prc_pkg::WU_W-1:0] WARMUP_CYC = prc_pkg::WU_W'(prc_pkg::WARMUP_CYC),
  parameter logic [prc_pkg::FH_W-1:0] FLOW_HOLD_CYC = prc_pkg::FH_W'(prc_pkg::FLOW_HOLD_CYC),
  parameter logic [prc_pkg::DEB_W-1:0] DEBOUNCE_CYC = prc_pkg::DEB_W'(prc_pkg::DEBOUNCE_CYC)
) (
  input wire logic core_clk_i,                   // 10 MHz core clock
  input wire logic sys_rst_i,                    // synchronous reset, high
  input wire prc_pkg::prc_cfg_t cfg_sw_i,        // configuration switches
  input wire logic buzzer_en_i,                  // buzzer use switch, live
  input wire logic remote_sel_i,                 // remote/local selector, high = remote
  input wire logic mp_start_i,                   // remote main pump start contact
  input wire logic bp_start_i,                   // remote booster start contact
  input wire logic trip_reset_i,                 // remote alarm/trip reset contact
  input wire logic mp_stop_i,                    // remote main pump stop contact
  input wire logic bp_stop_i,                    // remote booster stop contact
  input wire logic loc_start_i,                  // local start button
  input wire logic loc_stop_i,                   // local stop button
  input wire logic loc_reset_i,                  // local reset button
  input wire prc_pkg::prc_sense_t sense_i,       // raw alarm and trip causes
  output logic [$bits(prc_pkg::prc_stat_t)-1:0] stat_o // registered status outputs
);
  import prc_pkg::*;

  typedef struct packed {
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] deb;
    logic [NIN-1:0] deb_prev;
    logic [NIN-1:0][DEB_W-1:0] deb_cnt;
    logic [NIN-1:0][PW_W-1:0] pw_cnt;
    logic [NIN-1:0] cmd;
    logic cfg_done;
    prc_cfg_t cfg;
    logic [WU_W-1:0] wu_cnt;
    logic ready;
    logic [FH_W-1:0] hold_cnt;
    logic [7:0] alarm;
    logic [7:0] trip;
    logic estop_ok;
    logic mp_run;
    logic bp_run;
    logic lvl_arm;
    logic start_fail;
    prc_stat_t stat;
  } prc_state_t;

  prc_state_t s_q;
  prc_state_t s_d;

  logic [NIN-1:0] raw;
  assign raw = {remote_sel_i, loc_reset_i, loc_stop_i, loc_start_i, bp_stop_i,
                mp_stop_i, trip_reset_i, bp_start_i, mp_start_i};

  // next-state logic
  always_comb
  begin
    logic remote;
    logic rst_cmd;
    logic blocked;
    logic mp_start_req;
    logic mp_stop_req;
    logic bp_start_req;
    logic bp_stop_req;
    logic water_sup;
    logic flow_sup;
    logic [7:0] al_cause;
    logic trip_now;
    remote = 1'b0;
    rst_cmd = 1'b0;
    blocked = 1'b0;
    mp_start_req = 1'b0;
    mp_stop_req = 1'b0;
    bp_start_req = 1'b0;
    bp_stop_req = 1'b0;
    water_sup = 1'b0;
    flow_sup = 1'b0;
    al_cause = '0;
    trip_now = 1'b0;
    s_d = s_q;

    // two-stage synchroniser, debounce and pulse-width qualification
    s_d.sync1 = raw;
    s_d.sync2 = s_q.sync1;
    s_d.deb_prev = s_q.deb;
    for (int i = 0; i < NIN; i++)
    begin
      if (s_q.sync2[i] == s_q.deb[i])
        s_d.deb_cnt[i] = '0;
      else if (s_q.deb_cnt[i] >= DEBOUNCE_CYC - 1'b1)
      begin
        s_d.deb[i] = s_q.sync2[i];
        s_d.deb_cnt[i] = '0;
      end
      else
        s_d.deb_cnt[i] = s_q.deb_cnt[i] + 1'b1;
      // a command fires once the contact has been held the full width
      if (!s_q.deb[i])
        s_d.pw_cnt[i] = '0;
      else if (s_q.pw_cnt[i] != PULSE_CYC)
        s_d.pw_cnt[i] = s_q.pw_cnt[i] + 1'b1;
      s_d.cmd[i] = s_q.deb[i] && (s_q.pw_cnt[i] == PULSE_CYC - 1'b1);
    end

    // configuration capture one cycle after reset release
    if (!s_q.cfg_done)
    begin
      s_d.cfg = cfg_sw_i;
      s_d.cfg_done = 1'b1;
    end

    // warm-up count, counts up to WARMUP_CYC - 1, then sets ready
    if (!s_q.ready)
    begin
      if (s_q.wu_cnt >= WARMUP_CYC - 1'b1)
        s_d.ready = 1'b1;
      else
        s_d.wu_cnt = s_q.wu_cnt + 1'b1;
    end

    remote = s_q.deb[IN_REMOTE];
    rst_cmd = s_q.cmd[IN_RESET] || (s_q.deb[IN_LOC_RESET] && !s_q.deb_prev[IN_LOC_RESET]);

    // flow supervision window, water kept for the hold time after stop
    if (s_q.mp_run)
      s_d.hold_cnt = FLOW_HOLD_CYC;
    else if (s_q.hold_cnt != '0)
      s_d.hold_cnt = s_q.hold_cnt - 1'b1;
    flow_sup = !s_q.cfg.sup_op_only || s_q.mp_run;
    water_sup = flow_sup || (s_q.hold_cnt != '0);

    al_cause = sense_i.alarm;
    al_cause[AL_WATER] = sense_i.alarm[AL_WATER] && water_sup;
    al_cause[AL_SEAL] = sense_i.alarm[AL_SEAL] && flow_sup;
    al_cause[AL_DIL] = flow_sup && (s_q.cfg.zero_dil ? sense_i.dil_valve_open
                                                      : sense_i.alarm[AL_DIL]);

    // latched indications, a new cause wins over the reset
    s_d.alarm = al_cause | (s_q.alarm & {8{~rst_cmd}});
    s_d.trip = sense_i.trip | (s_q.trip & {8{~rst_cmd}});
    if (!sense_i.estop_closed)
      s_d.estop_ok = 1'b0;
    else if (rst_cmd)
      s_d.estop_ok = 1'b1;
    if (!s_q.cfg_done)
      s_d.estop_ok = sense_i.estop_closed;

    trip_now = (s_q.trip != '0) || !s_q.estop_ok;
    blocked = (s_q.alarm != '0) || trip_now;

    // start and stop requests by mode
    if (remote)
    begin
      if (s_q.cfg.pulse_mode)
      begin
        mp_start_req = s_q.cmd[IN_MP_START];
        mp_stop_req = s_q.cmd[IN_MP_STOP];
        bp_start_req = s_q.cmd[IN_BP_START];
        bp_stop_req = s_q.cmd[IN_BP_STOP];
      end
      else
      begin
        mp_start_req = s_q.deb[IN_MP_START] && s_q.lvl_arm && !s_q.mp_run;
        mp_stop_req = !s_q.deb[IN_MP_START];
        bp_start_req = s_q.deb[IN_BP_START] && !s_q.bp_run;
        bp_stop_req = !s_q.deb[IN_BP_START];
      end
    end
    else
    begin
      mp_start_req = s_q.deb[IN_LOC_START] && !s_q.deb_prev[IN_LOC_START];
      mp_stop_req = s_q.deb[IN_LOC_STOP] && !s_q.deb_prev[IN_LOC_STOP];
      bp_start_req = mp_start_req;
      bp_stop_req = mp_stop_req;
    end

    // level start re-arms once the start contact has been released
    if (!s_q.deb[IN_MP_START])
      s_d.lvl_arm = 1'b1;

    // main pump
    if (mp_start_req && !s_q.mp_run && s_q.ready)
    begin
      if (blocked)
        s_d.start_fail = 1'b1;
      else
        s_d.mp_run = 1'b1;
    end
    if (mp_stop_req)
      s_d.mp_run = 1'b0;
    if (rst_cmd && !(mp_start_req && !s_q.mp_run && blocked && s_q.ready))
      s_d.start_fail = 1'b0;

    // booster pump
    if (s_q.cfg.bp_by_signal)
    begin
      if (bp_start_req && s_q.mp_run && !blocked)
        s_d.bp_run = 1'b1;
      if (bp_stop_req)
        s_d.bp_run = 1'b0;
    end
    else
      s_d.bp_run = s_q.mp_run && sense_i.inlet_vac_ok;

    // switch to remote: optional automatic stop
    if (remote && !s_q.deb_prev[IN_REMOTE] && s_q.cfg.auto_stop_rem)
    begin
      s_d.mp_run = 1'b0;
      s_d.bp_run = 1'b0;
      s_d.lvl_arm = 1'b0;
    end

    // trips and emergency stop stop both pumps
    if (trip_now || !s_q.mp_run)
      s_d.bp_run = 1'b0;
    if (trip_now)
      s_d.mp_run = 1'b0;

    // registered status image
    s_d.stat.main_pump_run = s_q.mp_run;
    s_d.stat.booster_pump_run = s_q.bp_run;
    s_d.stat.estop_ok = s_q.estop_ok;
    s_d.stat.remote = remote;
    s_d.stat.alarm_any = (s_q.alarm != '0);
    s_d.stat.trip_any = (s_q.trip != '0);
    s_d.stat.alarm = s_q.alarm;
    s_d.stat.trip = s_q.trip;
    s_d.stat.buzzer = buzzer_en_i && blocked;
    s_d.stat.start_fail = s_q.start_fail;
    s_d.stat.ready = s_q.ready;
    s_d.stat.data_8bit = s_q.cfg.data_8bit;
  end

  // state register, defaults apply until switches are captured
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET;
      s_q.estop_ok <= 1'b1;
      s_q.lvl_arm <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign stat_o = s_q.stat;
endmodule : prc_remote_io
`default_nettype wire

/* verification/prc_checker.sv */
// Purpose: port-level assertions of the pump remote i/o block
// Assumes: one clock, synchronous reset high
// Notes: ages count cycles since a cause and saturate at 63
`timescale 1ns/1ps
`default_nettype none
module prc_checker (
  input wire logic core_clk_i, // core clock
  input wire logic sys_rst_i, // reset
  input wire logic buzzer_en_i, // buzzer switch
  input wire logic mp_start_i, // remote start contact
  input wire logic trip_reset_i, // remote reset contact
  input wire logic loc_start_i, // local start
  input wire logic loc_reset_i, // local reset
  input wire prc_pkg::prc_sense_t sense_i, // raw causes
  input wire logic [$bits(prc_pkg::prc_stat_t)-1:0] stat_o // status
);
  import prc_pkg::*;
  prc_stat_t st;
  logic [5:0] up_q, rs_q, sa_q;
  logic dil_c;
  assign st = prc_stat_t'(stat_o);
  assign dil_c = sense_i.alarm[AL_DIL] || sense_i.dil_valve_open;
  // ages since reset release, reset command and start contact
  always_ff @(posedge core_clk_i)
  begin
    up_q <= sys_rst_i ? 6'h00 : up_q + {5'h00, up_q != 6'h3F};
    rs_q <= sys_rst_i ? 6'h3F : (trip_reset_i || loc_reset_i) ? 6'h00 : rs_q + {5'h00, rs_q != 6'h3F};
    sa_q <= sys_rst_i ? 6'h3F : (mp_start_i || loc_start_i) ? 6'h00 : sa_q + {5'h00, sa_q != 6'h3F};
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_latch; $fell(st.alarm_any) || $fell(st.trip_any) |-> rs_q < 6'h28; endproperty
  a_latch: assert property (p_latch) else $error("latch cleared without reset");
  property p_estop; $rose(st.estop_ok) && up_q > 6'h04 |-> rs_q < 6'h28 && sense_i.estop_closed; endproperty
  a_estop: assert property (p_estop) else $error("estop cleared early");
  property p_ready; st.ready |=> st.ready; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  property p_run_rdy; $rose(st.main_pump_run) |-> st.ready; endproperty
  a_run_rdy: assert property (p_run_rdy) else $error("start before warm-up");
  property p_run_cause; $rose(st.main_pump_run) |-> sa_q < 6'h28; endproperty
  a_run_cause: assert property (p_run_cause) else $error("start without command");
  property p_run_alarm; $rose(st.main_pump_run) |-> !$past(st.alarm_any) && !$past(st.trip_any); endproperty
  a_run_alarm: assert property (p_run_alarm) else $error("start while latched");
  property p_fail; $rose(st.start_fail) |-> st.alarm_any || st.trip_any || !st.estop_ok; endproperty
  a_fail: assert property (p_fail) else $error("start failure without cause");
  property p_buzz; st.buzzer |-> $past(buzzer_en_i) || $past(buzzer_en_i, 2); endproperty
  a_buzz: assert property (p_buzz) else $error("buzzer while disabled");
  property p_bp; st.booster_pump_run |-> st.main_pump_run || $past(st.main_pump_run); endproperty
  a_bp: assert property (p_bp) else $error("booster without main pump");
  property p_dil; $rose(st.alarm[AL_DIL]) |-> $past(dil_c) || $past(dil_c, 2) || $past(dil_c, 3) || $past(dil_c, 4); endproperty
  a_dil: assert property (p_dil) else $error("dilution alarm without cause");
  property p_cfg; up_q > 6'h03 |-> $stable(st.data_8bit); endproperty
  a_cfg: assert property (p_cfg) else $error("data length changed");
endmodule : prc_checker
bind prc_remote_io prc_checker chk_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .buzzer_en_i(buzzer_en_i),
  .mp_start_i(mp_start_i), .trip_reset_i(trip_reset_i), .loc_start_i(loc_start_i), .loc_reset_i(loc_reset_i),
  .sense_i(sense_i), .stat_o(stat_o));
`default_nettype wire

/* verification/prc_equip_model.sv */
// Purpose: equipment side driving the remote contacts
// Assumes: contacts open read low
// Notes: one press at a time, busy while held
`timescale 1ns/1ps
`default_nettype none
module prc_equip_model (
  input wire logic core_clk_i, // core clock
  input wire logic go_i, // begin a press
  input wire logic [2:0] sel_i, // contact index
  input wire logic [7:0] len_i, // press length in cycles
  input wire logic mp_level_i, // maintained start level
  output logic busy_o, // press in progress
  output logic [4:0] contact_o // bp stop, mp stop, reset, bp start, mp start
);
  logic [7:0] cnt_q = 8'h00;
  logic [2:0] sel_q = 3'h0;
  // press length counter
  always_ff @(posedge core_clk_i)
  begin
    if (go_i && cnt_q == 8'h00)
    begin
      cnt_q <= len_i;
      sel_q <= sel_i;
    end
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign busy_o = cnt_q != 8'h00;
  // the selected contact stays closed for the whole press
  always_comb
  begin
    contact_o = 5'h00;
    if (busy_o)
      contact_o[sel_q] = 1'b1;
    contact_o[0] = contact_o[0] | mp_level_i;
  end
endmodule : prc_equip_model
`default_nettype wire

/* verification/testbench.sv */
// Purpose: self-checking bench of the pump remote i/o block
// Assumes: shortened counts set below
// Notes: status sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, buz = 1'b1, rem = 1'b0, lvl = 1'b0, go = 1'b0, busy, bz;
  logic [2:0] sel = 3'h0;
  logic [2:0] lb = 3'h0; // local buttons: reset, stop, start
  logic [7:0] len = 8'h00;
  logic [4:0] ct;
  logic [$bits(prc_stat_t)-1:0] so;
  prc_cfg_t cfg = CFG_RESET;
  prc_sense_t sn = 19'h00003;
  prc_stat_t sv;
  int n_fail = 0, total_checks = 0;
  always #50 clk = ~clk;
  // settled copies for comparison
  always @(negedge clk)
  begin
    sv <= prc_stat_t'(so);
    bz <= busy;
  end
  prc_remote_io #(.PULSE_CYC(21'h8), .WARMUP_CYC(27'h14), .FLOW_HOLD_CYC(34'h32), .DEBOUNCE_CYC(17'h3)) dut_u (
    .core_clk_i(clk), .sys_rst_i(rst), .cfg_sw_i(cfg), .buzzer_en_i(buz), .remote_sel_i(rem),
    .mp_start_i(ct[0]), .bp_start_i(ct[1]), .trip_reset_i(ct[2]), .mp_stop_i(ct[3]), .bp_stop_i(ct[4]),
    .loc_start_i(lb[0]), .loc_stop_i(lb[1]), .loc_reset_i(lb[2]), .sense_i(sn), .stat_o(so));
  prc_equip_model eq_u (.core_clk_i(clk), .go_i(go), .sel_i(sel), .len_i(len), .mp_level_i(lvl),
    .busy_o(busy), .contact_o(ct));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t status %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one contact press through the equipment model
  task automatic press(input logic [2:0] s, input logic [7:0] n);
    int i;
    i = 0;
    go <= 1'b1;
    sel <= s;
    len <= n;
    tick(1);
    go <= 1'b0;
    do
    begin
      tick(1);
      i++;
    end
    while (bz && i < 300);
    if (i >= 300)
    begin
      n_fail++;
      conclude();
    end
    tick(8);
  endtask : press
  // short pulse of a raw cause
  task automatic cause(input logic [18:0] m);
    sn <= sn | m;
    tick(3);
    sn <= sn & ~m;
    tick(5);
  endtask : cause
  initial
  begin
    tick(20);
    rst <= 1'b0;
    tick(5);
    chk(sv.ready, 8'h00);
    tick(25);
    chk({sv.ready, sv.data_8bit}, 8'h03);
    // local start and stop buttons, booster follows by inlet vacuum
    lb <= 3'h1;
    tick(8);
    lb <= 3'h0;
    tick(8);
    chk({sv.main_pump_run, sv.booster_pump_run}, 8'h03);
    lb <= 3'h2;
    tick(8);
    lb <= 3'h0;
    tick(8);
    chk({sv.main_pump_run, sv.booster_pump_run}, 8'h00);
    cfg <= 6'h1F;
    rem <= 1'b1;
    tick(10);
    chk({sv.remote, sv.data_8bit}, 8'h03);
    lvl <= 1'b1;
    tick(25);
    chk({sv.main_pump_run, sv.booster_pump_run}, 8'h03);
    lvl <= 1'b0;
    tick(25);
    chk(sv.main_pump_run, 8'h00);
    cause(19'h00800);
    chk({sv.alarm_any, sv.alarm[AL_WATER], sv.buzzer}, 8'h07);
    buz <= 1'b0;
    tick(3);
    chk(sv.buzzer, 8'h00);
    lvl <= 1'b1;
    tick(25);
    chk({sv.main_pump_run, sv.start_fail}, 8'h01);
    lvl <= 1'b0;
    press(3'h2, 8'h04);
    chk(sv.alarm_any, 8'h01);
    press(3'h2, 8'h14);
    chk({sv.alarm_any, sv.start_fail}, 8'h00);
    cause(19'h02000);
    chk(sv.alarm[AL_DIL], 8'h01);
    lb <= 3'h4;
    tick(8);
    lb <= 3'h0;
    tick(8);
    chk(sv.alarm_any, 8'h00);
    sn.estop_closed <= 1'b0;
    tick(5);
    chk(sv.estop_ok, 8'h00);
    sn.estop_closed <= 1'b1;
    tick(10);
    chk(sv.estop_ok, 8'h00);
    press(3'h2, 8'h14);
    chk(sv.estop_ok, 8'h01);
    rst <= 1'b1;
    tick(20);
    rst <= 1'b0;
    tick(30);
    chk(sv.data_8bit, 8'h00);
    press(3'h0, 8'h14);
    chk({sv.main_pump_run, sv.booster_pump_run}, 8'h02);
    press(3'h1, 8'h14);
    chk(sv.booster_pump_run, 8'h01);
    // leave remote and come back: automatic stop is selected
    rem <= 1'b0;
    tick(15);
    rem <= 1'b1;
    tick(15);
    chk({sv.main_pump_run, sv.booster_pump_run}, 8'h00);
    press(3'h0, 8'h14);
    chk(sv.main_pump_run, 8'h01);
    cause(19'h00004);
    chk(sv.alarm[AL_DIL], 8'h01);
    press(3'h2, 8'h14);
    press(3'h3, 8'h14);
    chk({sv.main_pump_run, sv.booster_pump_run}, 8'h00);
    cause(19'h00800);
    chk(sv.alarm[AL_WATER], 8'h01);
    press(3'h2, 8'h14);
    tick(60);
    cause(19'h00800);
    chk(sv.alarm[AL_WATER], 8'h00);
    // a short trip cause stays latched and blocks the next start
    cause(19'h00008);
    chk({sv.trip_any, sv.trip[0]}, 8'h03);
    press(3'h0, 8'h14);
    chk({sv.main_pump_run, sv.start_fail}, 8'h01);
    conclude();
  end
endmodule : testbench
`default_nettype wire
